// ===== logic/rxirq_pkg.sv
// Package for the receiver interrupt combiner and pin control block.
// Holds register offsets, field positions, reset values and pin timing.
package rxirq_pkg;

   // Register offsets within the 8-bit register map
   localparam logic [7:0] RXIRQ_OFF_SOURCE      = 8'h3f;
   localparam logic [7:0] RXIRQ_OFF_PIN_CFG     = 8'h40;
   localparam logic [7:0] RXIRQ_OFF_MANUAL_MASK = 8'h4b;
   localparam logic [7:0] RXIRQ_OFF_CABLE_RAW   = 8'h6f;
   localparam logic [7:0] RXIRQ_OFF_CABLE_ST    = 8'h70;
   localparam logic [7:0] RXIRQ_OFF_CABLE_CLR   = 8'h71;
   localparam logic [7:0] RXIRQ_OFF_CABLE_MASK  = 8'h73;
   localparam logic [7:0] RXIRQ_OFF_KEY_RAW     = 8'h88;
   localparam logic [7:0] RXIRQ_OFF_KEY_ST      = 8'h89;
   localparam logic [7:0] RXIRQ_OFF_KEY_CLR     = 8'h8a;
   localparam logic [7:0] RXIRQ_OFF_KEY_MASK    = 8'h8c;
   localparam logic [7:0] RXIRQ_OFF_MANUAL_ST   = 8'h4c;

   // Field positions
   localparam int RXIRQ_BIT_RX_ACTIVE   = 0;
   localparam int RXIRQ_BIT_TXA_N       = 1;
   localparam int RXIRQ_BIT_TXB_N       = 2;
   localparam int RXIRQ_BIT_DRIVE_LO    = 0;
   localparam int RXIRQ_BIT_FORCE       = 2;
   localparam int RXIRQ_BIT_IGNORE_MASK = 4;
   localparam int RXIRQ_BIT_LEN_LO      = 6;
   localparam int RXIRQ_BIT_MANUAL_MASK = 7;
   localparam int RXIRQ_BIT_PORT0       = 3;
   localparam int RXIRQ_BIT_MANUAL_ST   = 0;

   // Reset values
   localparam logic [1:0] RXIRQ_RST_LEN   = 2'h0;
   localparam logic [1:0] RXIRQ_RST_DRIVE = 2'h0;

   // Pin drive styles
   localparam logic [1:0] RXIRQ_DRV_OPEN_DRAIN = 2'h0;
   localparam logic [1:0] RXIRQ_DRV_LOW_ACTIVE = 2'h1;
   localparam logic [1:0] RXIRQ_DRV_HIGH_ACT   = 2'h2;
   localparam logic [1:0] RXIRQ_DRV_DISABLED   = 2'h3;

   // Pulse lengths in sys_clk periods
   localparam logic [1:0] RXIRQ_LEN_HOLD  = 2'h3;
   localparam logic [6:0] RXIRQ_LEN_SHORT = 7'h04;
   localparam logic [6:0] RXIRQ_LEN_MID   = 7'h10;
   localparam logic [6:0] RXIRQ_LEN_LONG  = 7'h40;

   // Pin signal group
   typedef struct packed {
      logic out;
      logic oe;
   } rxirq_pin_t;

   // Control fields held in register 0x40
   typedef struct packed {
      logic [1:0] len_sel;
      logic       ignore_mask;
      logic       force_req;
      logic [1:0] drive_sel;
   } rxirq_cfg_t;

endpackage

// ===== logic/rxirq_latch.sv
// One receiver interrupt source: raw bit, latched status, mask, clear.
// Assumes event and clear come from logic on sys_clk.
`timescale 1ns/100ps
module rxirq_latch #(
   parameter bit EDGE_TYPE = 1'b0
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Source and controls
   input  wire logic src_in,
   input  wire logic mask_in,
   input  wire logic ignore_mask,
   input  wire logic clear_in,
   // Results
   output logic      raw_out,
   output logic      status_out,
   output logic      irq_out
);
   logic raw_r;
   logic src_prev_r;
   logic status_r;
   wire  src_rise   = src_in & ~src_prev_r;
   wire  raw_now    = EDGE_TYPE ? raw_r : src_in;
   wire  raw_change = EDGE_TYPE ? src_rise : (src_in ^ src_prev_r);
   wire  set_status = raw_change & (mask_in | ignore_mask);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_prev_r <= 1'b0;
         raw_r      <= 1'b0;
         status_r   <= 1'b0;
      end else begin
         src_prev_r <= src_in;
         // Edge raw latches until cleared; set wins over clear
         if (src_rise)
            raw_r <= 1'b1;
         else if (clear_in)
            raw_r <= 1'b0;
         if (set_status)
            status_r <= 1'b1;
         else if (clear_in)
            status_r <= 1'b0;
      end
   end

   assign raw_out    = raw_now;
   assign status_out = status_r;
   assign irq_out    = status_r & mask_in;
endmodule

// ===== logic/rxirq_pulse.sv
// Pin pulse timer and drive style for the combined interrupt.
// Assumes req_in is a level on sys_clk.
`timescale 1ns/100ps
module rxirq_pulse
   import rxirq_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Request and configuration
   input  wire logic       req_in,
   input  wire logic [1:0] len_sel,
   input  wire logic [1:0] drive_sel,
   // Pin
   output rxirq_pin_t      pin
);
   logic       req_prev_r;
   logic       active_r;
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   wire  start  = req_in & ~req_prev_r;
   wire  [6:0] len = (len_sel == 2'h0) ? RXIRQ_LEN_SHORT :
                     (len_sel == 2'h1) ? RXIRQ_LEN_MID : RXIRQ_LEN_LONG;
   wire  hold   = (len_sel == RXIRQ_LEN_HOLD);
   wire  done   = (cnt_r == len - 7'h01);
   wire  act    = hold ? req_in : active_r;

   assign cnt_nxt = cnt_r + 7'h01;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_prev_r <= 1'b0;
         active_r   <= 1'b0;
         cnt_r      <= 7'h00;
      end else begin
         req_prev_r <= req_in;
         if (start && !hold) begin
            active_r <= 1'b1;
            cnt_r    <= 7'h00;
         end else if (active_r && done) begin
            active_r <= 1'b0;
         end else if (active_r) begin
            cnt_r <= cnt_nxt;
         end
      end
   end

   // Pin style: active low open drain or push-pull, high, or off
   always_comb begin
      case (drive_sel)
         RXIRQ_DRV_OPEN_DRAIN: pin = '{out: 1'b0, oe: act};
         RXIRQ_DRV_LOW_ACTIVE: pin = '{out: ~act, oe: 1'b1};
         RXIRQ_DRV_HIGH_ACT:   pin = '{out: act, oe: 1'b1};
         default:              pin = '{out: 1'b0, oe: 1'b0};
      endcase
   end
endmodule

// ===== logic/rxirq_top.sv
// Receiver interrupt controller, source combiner and interrupt pin.
// Assumes an 8-bit register port on sys_clk and async pin inputs.
// Notes on behaviour
// - OR receiver and both transmitter requests to pin
// - Pulse length code: 4, 16, 64, hold
// - Drive code: open drain, low, high, off
// - Manual force creates test request
// - Forced request reaches pin only when masked in
// - Receiver active bit reads one while pending
// - First transmitter bit reads zero while pending
// - Second transmitter bit reads zero while pending
// - Source indications are independent
// - Cable raw bit follows supply sense live
// - Key write raw bit latches until cleared
// - Raw change under mask sets status
// - Status stays set until cleared
// - Mask zero blocks cable and key status setting unless ignore-mask is set
// - Write one clears, bit self clears
// - Cable mask routes change to pin
// - Key mask routes key write to pin
// - Status bits hold until own clear
// - No second pulse while request pending
// - Ignore-mask option latches cable and key status without pin
`timescale 1ns/100ps
module rxirq_top
   import rxirq_pkg::*;
(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   // Register port
   input  wire logic [7:0]       reg_addr,
   input  wire logic             reg_wr,
   input  wire logic [7:0]       reg_wdata,
   output logic      [7:0]       reg_rdata,
   // Event sources
   input  wire logic             port0_supply_sense,
   input  wire logic             port0_key_write_strobe,
   input  wire logic             tx_first_ctrl_irq,
   input  wire logic             tx_second_ctrl_irq,
   // Interrupt pin
   output rxirq_pin_t            irq_out_pin
);
   rxirq_cfg_t cfg_r;
   logic       manual_irq_pin_mask_r;
   logic       port0_cable_change_mask_r;
   logic       port0_key_write_mask_r;
   logic [2:0] sense_sync_r;
   logic       sense_r;
   logic       manual_irq_status_r;
   logic [7:0] rdata_nxt;
   logic [7:0] rdata_r;

   // Register write decode
   wire wr_cfg   = reg_wr & (reg_addr == RXIRQ_OFF_PIN_CFG);
   wire wr_mman  = reg_wr & (reg_addr == RXIRQ_OFF_MANUAL_MASK);
   wire wr_cmask = reg_wr & (reg_addr == RXIRQ_OFF_CABLE_MASK);
   wire wr_kmask = reg_wr & (reg_addr == RXIRQ_OFF_KEY_MASK);
   // Clear pulses last one cycle, so the bits read back zero
   wire cable_clear = reg_wr & (reg_addr == RXIRQ_OFF_CABLE_CLR) &
                      reg_wdata[RXIRQ_BIT_PORT0];
   wire key_clear   = reg_wr & (reg_addr == RXIRQ_OFF_KEY_CLR) &
                      reg_wdata[RXIRQ_BIT_PORT0];
   wire man_clear   = reg_wr & (reg_addr == RXIRQ_OFF_MANUAL_ST) &
                      reg_wdata[RXIRQ_BIT_MANUAL_ST];

   // Supply sense is a pin: three stages, change when last two agree
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         sense_sync_r <= 3'h0;
      else
         sense_sync_r <= {sense_sync_r[1:0], port0_supply_sense};
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         sense_r <= 1'b0;
      else if (sense_sync_r[1] == sense_sync_r[2])
         sense_r <= sense_sync_r[2];
   end

   // Control registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r                     <= '{len_sel: RXIRQ_RST_LEN,
                                        ignore_mask: 1'b0,
                                        force_req: 1'b0,
                                        drive_sel: RXIRQ_RST_DRIVE};
         manual_irq_pin_mask_r     <= 1'b0;
         port0_cable_change_mask_r <= 1'b0;
         port0_key_write_mask_r    <= 1'b0;
      end else begin
         if (wr_cfg) begin
            cfg_r.len_sel     <= reg_wdata[RXIRQ_BIT_LEN_LO +: 2];
            cfg_r.ignore_mask <= reg_wdata[RXIRQ_BIT_IGNORE_MASK];
            cfg_r.force_req   <= reg_wdata[RXIRQ_BIT_FORCE];
            cfg_r.drive_sel   <= reg_wdata[RXIRQ_BIT_DRIVE_LO +: 2];
         end
         if (wr_mman)
            manual_irq_pin_mask_r <= reg_wdata[RXIRQ_BIT_MANUAL_MASK];
         if (wr_cmask)
            port0_cable_change_mask_r <= reg_wdata[RXIRQ_BIT_PORT0];
         if (wr_kmask)
            port0_key_write_mask_r <= reg_wdata[RXIRQ_BIT_PORT0];
      end
   end

   // Receiver sources
   logic port0_cable_present_now;
   logic port0_cable_change_status;
   logic cable_irq;
   logic port0_key_write_seen;
   logic port0_key_write_status;
   logic key_irq;

   rxirq_latch #(.EDGE_TYPE(1'b0)) u_cable (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .src_in      (sense_r),
      .mask_in     (port0_cable_change_mask_r),
      .ignore_mask (cfg_r.ignore_mask),
      .clear_in    (cable_clear),
      .raw_out     (port0_cable_present_now),
      .status_out  (port0_cable_change_status),
      .irq_out     (cable_irq)
   );

   rxirq_latch #(.EDGE_TYPE(1'b1)) u_key (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .src_in      (port0_key_write_strobe),
      .mask_in     (port0_key_write_mask_r),
      .ignore_mask (cfg_r.ignore_mask),
      .clear_in    (key_clear),
      .raw_out     (port0_key_write_seen),
      .status_out  (port0_key_write_status),
      .irq_out     (key_irq)
   );

   // Manual forced request, latched while forced and masked in
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         manual_irq_status_r <= 1'b0;
      else if (cfg_r.force_req && manual_irq_pin_mask_r)
         manual_irq_status_r <= 1'b1;
      else if (man_clear)
         manual_irq_status_r <= 1'b0;
   end

   wire manual_irq = manual_irq_status_r & manual_irq_pin_mask_r;
   wire rx_ctrl_irq_active = cable_irq | key_irq | manual_irq;
   wire tx_first_ctrl_irq_n  = ~tx_first_ctrl_irq;
   wire tx_second_ctrl_irq_n = ~tx_second_ctrl_irq;
   wire combined_req = rx_ctrl_irq_active | tx_first_ctrl_irq |
                       tx_second_ctrl_irq;

   rxirq_pulse u_pulse (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .req_in    (combined_req),
      .len_sel   (cfg_r.len_sel),
      .drive_sel (cfg_r.drive_sel),
      .pin       (irq_out_pin)
   );

   // Read mux; unmapped and write-only offsets read zero
   always_comb begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         RXIRQ_OFF_SOURCE: begin
            rdata_nxt[RXIRQ_BIT_RX_ACTIVE] = rx_ctrl_irq_active;
            rdata_nxt[RXIRQ_BIT_TXA_N]     = tx_first_ctrl_irq_n;
            rdata_nxt[RXIRQ_BIT_TXB_N]     = tx_second_ctrl_irq_n;
         end
         RXIRQ_OFF_PIN_CFG: begin
            rdata_nxt[RXIRQ_BIT_LEN_LO +: 2]    = cfg_r.len_sel;
            rdata_nxt[RXIRQ_BIT_IGNORE_MASK]    = cfg_r.ignore_mask;
            rdata_nxt[RXIRQ_BIT_FORCE]          = cfg_r.force_req;
            rdata_nxt[RXIRQ_BIT_DRIVE_LO +: 2]  = cfg_r.drive_sel;
         end
         RXIRQ_OFF_MANUAL_MASK:
            rdata_nxt[RXIRQ_BIT_MANUAL_MASK] = manual_irq_pin_mask_r;
         RXIRQ_OFF_MANUAL_ST:
            rdata_nxt[RXIRQ_BIT_MANUAL_ST] = manual_irq_status_r;
         RXIRQ_OFF_CABLE_RAW:
            rdata_nxt[RXIRQ_BIT_PORT0] = port0_cable_present_now;
         RXIRQ_OFF_CABLE_ST:
            rdata_nxt[RXIRQ_BIT_PORT0] = port0_cable_change_status;
         RXIRQ_OFF_CABLE_MASK:
            rdata_nxt[RXIRQ_BIT_PORT0] = port0_cable_change_mask_r;
         RXIRQ_OFF_KEY_RAW:
            rdata_nxt[RXIRQ_BIT_PORT0] = port0_key_write_seen;
         RXIRQ_OFF_KEY_ST:
            rdata_nxt[RXIRQ_BIT_PORT0] = port0_key_write_status;
         RXIRQ_OFF_KEY_MASK:
            rdata_nxt[RXIRQ_BIT_PORT0] = port0_key_write_mask_r;
         default:
            rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         rdata_r <= 8'h00;
      else
         rdata_r <= rdata_nxt;
   end

   assign reg_rdata = rdata_r;
endmodule

// ===== tb/rxirq_checker.sv
// Checker for pin timing, drive style and transmitter source bits.
// Bound to rxirq_top; shadows the pin config register from port writes.
`timescale 1ns/100ps
module rxirq_checker (
   // Clock and reset
   input wire logic                  sys_clk,
   input wire logic                  rst_n,
   // Register port
   input wire logic [7:0]            reg_addr,
   input wire logic                  reg_wr,
   input wire logic [7:0]            reg_wdata,
   input wire logic [7:0]            reg_rdata,
   // Sources and pin
   input wire logic                  tx_first_ctrl_irq,
   input wire logic                  tx_second_ctrl_irq,
   input wire rxirq_pkg::rxirq_pin_t irq_out_pin
);
   import rxirq_pkg::*;
   logic [1:0] drv_r;
   logic [1:0] len_r;
   logic [6:0] run_r;
   logic       act;
   logic [6:0] lim;
   // Pin active as seen on the wire for the current style
   assign act = (drv_r == RXIRQ_DRV_OPEN_DRAIN) ? irq_out_pin.oe :
                (drv_r == RXIRQ_DRV_LOW_ACTIVE) ? !irq_out_pin.out :
                (drv_r == RXIRQ_DRV_HIGH_ACT) && irq_out_pin.out;
   assign lim = (len_r == 2'h0) ? RXIRQ_LEN_SHORT :
                (len_r == 2'h1) ? RXIRQ_LEN_MID : RXIRQ_LEN_LONG;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         drv_r <= RXIRQ_RST_DRIVE;
         len_r <= RXIRQ_RST_LEN;
         run_r <= 7'h00;
      end else begin
         if (reg_wr && reg_addr == RXIRQ_OFF_PIN_CFG) begin
            drv_r <= reg_wdata[1:0];
            len_r <= reg_wdata[7:6];
         end
         run_r <= act ? run_r + {6'h00, run_r != 7'h7f} : 7'h00;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_held;
      tx_first_ctrl_irq ##1 tx_first_ctrl_irq;
   endsequence
   sequence s_pulse_end;
      $fell(act) && len_r != RXIRQ_LEN_HOLD;
   endsequence
   chk_drive_off: assert property (drv_r == 2'h3 |-> !irq_out_pin.oe)
      else $error("pin driven while disabled");
   chk_open_drain: assert property (drv_r == 2'h0 |-> !irq_out_pin.out)
      else $error("open drain pin driven high");
   chk_low_driven: assert property (drv_r == 2'h1 |-> irq_out_pin.oe)
      else $error("low style pin not driven");
   chk_high_driven: assert property (drv_r == 2'h2 |-> irq_out_pin.oe)
      else $error("high style pin not driven");
   chk_pulse_len: assert property (s_pulse_end |-> run_r == lim)
      else $error("pin pulse length wrong");
   chk_pulse_cap: assert property (len_r != 2'h3 |-> run_r <= lim)
      else $error("pin pulse too long");
   chk_hold_mode: assert property (s_held ##0 (len_r == 2'h3 &&
      drv_r != 2'h3) |-> act) else $error("held request not on pin");
   chk_tx_bits: assert property ($past(rst_n) &&
      $past(reg_addr) == RXIRQ_OFF_SOURCE |-> reg_rdata[2:1] ==
      ~{$past(tx_second_ctrl_irq), $past(tx_first_ctrl_irq)})
      else $error("transmitter source bits wrong");
endmodule

bind rxirq_top rxirq_checker i_rxirq_checker (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .tx_first_ctrl_irq(tx_first_ctrl_irq),
   .tx_second_ctrl_irq(tx_second_ctrl_irq), .irq_out_pin(irq_out_pin));

// ===== tb/rxirq_host_model.sv
// Host watching the interrupt wire: resolves the level and times pulses.
// Assumes a pull-up on the wire and an active level set by the bench.
`timescale 1ns/100ps
module rxirq_host_model (
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   // Pin and active level
   input  wire rxirq_pkg::rxirq_pin_t pin,
   input  wire logic                  active_lvl,
   // Observations
   output logic                       wire_lvl,
   output logic [7:0]                 last_len,
   output logic [7:0]                 pulses
);
   import rxirq_pkg::*;
   logic [7:0] run_r;
   assign wire_lvl = pin.oe ? pin.out : 1'b1;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_r <= 8'h00;
         last_len <= 8'h00;
         pulses <= 8'h00;
      end else if (wire_lvl === active_lvl) begin
         run_r <= run_r + 8'h01;
      end else if (run_r != 8'h00) begin
         last_len <= run_r;
         pulses <= pulses + 8'h01;
         run_r <= 8'h00;
      end
   end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the receiver interrupt combiner and pin.
// Drives inputs at falling edges; the host model times pin pulses.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin \
   checked++; \
   if ((gt) !== (ex)) begin \
      failures++; \
      $display("mismatch %s expected %h seen %h", nm, ex, gt); \
   end \
end
module testbench;
   import rxirq_pkg::*;
   logic       sys_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic       reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic       supply = 1'b0;
   logic       key_stb = 1'b0;
   logic       tx_a = 1'b0;
   logic       tx_b = 1'b0;
   rxirq_pin_t pin;
   logic       lvl;
   logic [7:0] plen;
   logic [7:0] npul;
   logic [7:0] np0;
   logic [7:0] rtbl [9] = '{8'h40, 8'h4b, 8'h4c, 8'h6f, 8'h70, 8'h73,
                            8'h88, 8'h89, 8'h8c};
   int         failures = 0;
   int         checked = 0;
   int         cycles = 0;
   always #2 sys_clk = ~sys_clk;
   rxirq_top i_rxirq_top (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .port0_supply_sense(supply), .port0_key_write_strobe(key_stb),
      .tx_first_ctrl_irq(tx_a), .tx_second_ctrl_irq(tx_b),
      .irq_out_pin(pin));
   rxirq_host_model i_rxirq_host_model (
      .sys_clk(sys_clk), .rst_n(rst_n), .pin(pin), .active_lvl(1'b0),
      .wire_lvl(lvl), .last_len(plen), .pulses(npul));
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      // Idle cycle keeps back-to-back writes apart
      @(negedge sys_clk);
   endtask
   task automatic ck(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      @(negedge sys_clk);
      `CHK("reg_rdata", e, reg_rdata)
   endtask
   task automatic stb;
      key_stb = 1'b1;
      wt(1);
      key_stb = 1'b0;
      wt(8);
   endtask
   task automatic end_sim;
      if (failures == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim;
      end
   end
   initial begin
      wt(4);
      rst_n = 1'b1;
      wt(1);
      for (int i = 0; i < 9; i++) ck(rtbl[i], 8'h00);
      wr(8'h3f, 8'hff);
      wr(8'h00, 8'hff);
      ck(8'h40, 8'h00);
      ck(8'h3f, 8'h06);
      np0 = npul;
      tx_b = 1'b1;
      ck(8'h3f, 8'h02);
      tx_a = 1'b1;
      ck(8'h3f, 8'h00);
      wt(8);
      `CHK("pulses", np0 + 8'h01, npul)
      tx_a = 1'b0;
      tx_b = 1'b0;
      supply = 1'b1;
      wt(10);
      ck(8'h6f, 8'h08);
      ck(8'h70, 8'h00);
      wr(8'h73, 8'h08);
      np0 = npul;
      supply = 1'b0;
      wt(12);
      ck(8'h6f, 8'h00);
      ck(8'h70, 8'h08);
      ck(8'h3f, 8'h07);
      `CHK("pulses", np0 + 8'h01, npul)
      `CHK("pulse_len", 8'h04, plen)
      wr(8'h71, 8'h00);
      ck(8'h70, 8'h08);
      wr(8'h71, 8'h08);
      ck(8'h70, 8'h00);
      ck(8'h3f, 8'h06);
      for (int m = 0; m < 2; m++) begin
         wr(8'h8c, {4'h0, m[0], 3'h0});
         np0 = npul;
         stb();
         ck(8'h88, 8'h08);
         ck(8'h89, {4'h0, m[0], 3'h0});
         `CHK("pulses", np0 + {7'h00, m[0]}, npul)
         wr(8'h8a, 8'h08);
         ck(8'h88, 8'h00);
      end
      np0 = npul;
      stb();
      supply = 1'b1;
      wt(12);
      ck(8'h70, 8'h08);
      `CHK("pulses", np0 + 8'h01, npul)
      wr(8'h71, 8'h08);
      wr(8'h8a, 8'h08);
      ck(8'h89, 8'h00);
      for (int c = 0; c < 3; c++) begin
         wr(8'h40, {c[1:0], 6'h01});
         tx_a = 1'b1;
         wt(80);
         tx_a = 1'b0;
         wt(2);
         `CHK("pulse_len", 8'h04 << (2 * c), plen)
      end
      wr(8'h40, 8'hc0);
      tx_a = 1'b1;
      for (int d = 0; d < 4; d++) begin
         wr(8'h40, {6'h30, d[1:0]});
         wt(3);
         `CHK("pin_oe", d != 3, pin.oe)
         `CHK("wire_lvl", d >= 2, lvl)
      end
      tx_a = 1'b0;
      wr(8'h40, 8'hc1);
      tx_a = 1'b1;
      wt(100);
      `CHK("wire_lvl", 1'b0, lvl)
      tx_a = 1'b0;
      wt(3);
      `CHK("wire_lvl", 1'b1, lvl)
      wr(8'h40, 8'h05);
      np0 = npul;
      wt(10);
      `CHK("pulses", np0, npul)
      wr(8'h4b, 8'h80);
      wt(10);
      `CHK("pulses", np0 + 8'h01, npul)
      ck(8'h4c, 8'h01);
      ck(8'h4b, 8'h80);
      wr(8'h40, 8'h01);
      wr(8'h4c, 8'h01);
      ck(8'h4c, 8'h00);
      wr(8'h73, 8'h00);
      wr(8'h40, 8'h11);
      np0 = npul;
      supply = 1'b0;
      wt(12);
      ck(8'h70, 8'h08);
      ck(8'h3f, 8'h06);
      `CHK("pulses", np0, npul)
      wr(8'h71, 8'h08);
      ck(8'h70, 8'h00);
      end_sim;
   end
endmodule
